// file: phy_strap_config_loader.sv
// Strap capture and strap-derived register defaults of the transceiver.
`timescale 1ns/1ps
`default_nettype none
module phy_strap_config_loader (
	// Clock and power-on reset.
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// Hardware reset pin, active low.
	input wire logic i_hw_reset_n,
	// Strap pads: receive pins, interface select and indicator.
	input wire logic [7:0] i_pad_in,
	output logic [7:0] o_pad_out,
	output logic [7:0] o_pad_oe,
	// Normal pad functions from the core; bit 7 is link activity.
	input wire logic [7:0] i_pad_func,
	// Management register port.
	input wire logic [4:0] i_reg_phy_addr,
	input wire logic [4:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [15:0] o_reg_rdata,
	output logic o_reg_rd_ack,
	// Configuration to the 10/100 logic.
	output logic o_speed_100,
	output logic o_full_duplex,
	output logic o_autoneg_en,
	output logic [3:0] o_adv_abilities,
	output logic o_crs_on_tx,
	output logic o_repeater_mode,
	output logic o_power_down,
	output logic o_soft_reset,
	output logic o_rmii_mode,
	output logic [4:0] o_phy_address,
	output logic [4:0] o_scrambler_seed,
	output logic o_regulator_off,
	output logic o_config_ready
);

	// ==========================================================
	// Declarations.
	// ==========================================================
	logic [8:0] sync_out; // Pads plus reset pin, synchronised.
	logic [7:0] pad_sync; // Synchronised pad levels.
	logic hw_n_sync; // Synchronised reset pin level.
	logic hw_rst_req; // Hardware reset pin asserted.
	logic reg_clear; // Power-on or pin reset in force.
	phy_strap_pkg::load_state_e state_reg; // Loader sequence state.
	phy_strap_pkg::load_state_e state_next; // Next loader state.
	logic [1:0] settle_cnt_reg; // Cycles waited for synchronisers.
	logic capture; // One-cycle strap capture pulse.
	logic running; // Straps latched and pads driven.
	logic addr_match; // Frame address equals ours.
	logic wr_hit; // Accepted register write.
	logic rd_hit; // Accepted register read.
	logic [15:0] ctrl_reg; // Basic control register.
	logic [15:0] adv_reg; // Advertisement register.
	logic [4:0] phy_addr_reg; // Management address.
	logic [2:0] mode_field_reg; // Mode field of special modes register.
	logic kind_reg; // MAC interface kind, high for RMII.
	logic regulator_disable_strap_reg; // Latched regulator-disable strap.
	logic strap_pd_reg; // Power-down chosen by strap.
	logic [2:0] strap_mode; // Mode straps as sampled now.
	logic [3:0] ctrl_def; // Control default pattern for strap mode.
	logic [3:0] adv_def; // Ability default for strap mode.
	logic load_ctrl; // Strap mode loads control defaults.
	logic load_adv; // Strap mode loads ability defaults.
	logic [15:0] special_view; // Read view of special modes register.

	// ==========================================================
	// Pad and pin synchronisers.
	// ==========================================================
	// Every pad level and the reset pin pass two flip-flops first.
	strap_sync #(
		.WIDTH(9)
	) u_sync (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_async({i_hw_reset_n, i_pad_in}),
		.o_sync(sync_out)
	);

	// Split the synchronised word; pin reads low until filled.
	assign pad_sync = sync_out[7:0];
	assign hw_n_sync = sync_out[8];
	assign hw_rst_req = ~hw_n_sync;
	assign reg_clear = i_sys_rst | hw_rst_req;
	// Mode straps sit on the receive data 0, data 1 and collision pads.
	assign strap_mode = pad_sync[phy_strap_pkg::PAD_MODE_LSB +: 3];
	assign running = (state_reg == phy_strap_pkg::ST_RUN);

	// ==========================================================
	// Loader sequence.
	// ==========================================================
	// Waits for the pad synchronisers to fill after release.
	always_comb begin
		state_next = state_reg;
		capture = 1'b0;
		case (state_reg)
			phy_strap_pkg::ST_RESET: begin
				// Held here for either reset source.
				if (!hw_rst_req) begin
					state_next = phy_strap_pkg::ST_SETTLE;
				end
			end
			phy_strap_pkg::ST_SETTLE: begin
				// A new pin reset restarts the wait.
				if (hw_rst_req) begin
					state_next = phy_strap_pkg::ST_RESET;
				end else if (settle_cnt_reg == phy_strap_pkg::STRAP_SETTLE_CYCLES - 2'h1) begin
					capture = 1'b1;
					state_next = phy_strap_pkg::ST_RUN;
				end
			end
			phy_strap_pkg::ST_RUN: begin
				// Pin reset relatches all straps.
				if (hw_rst_req) begin
					state_next = phy_strap_pkg::ST_RESET;
				end
			end
			default: begin
				state_next = phy_strap_pkg::ST_RESET;
			end
		endcase
	end

	// State register; power-on reset also lands in the reset state.
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			state_reg <= phy_strap_pkg::ST_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// Settle counter runs only while waiting.
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst || state_reg != phy_strap_pkg::ST_SETTLE) begin
			settle_cnt_reg <= 2'h0;
		end else begin
			settle_cnt_reg <= settle_cnt_reg + 2'h1;
		end
	end

	// ==========================================================
	// Mode strap decode.
	// ==========================================================
	// Chooses the defaults that a strap mode loads.
	always_comb begin
		ctrl_def = phy_strap_pkg::CTRL_DEF_10_HALF;
		adv_def = phy_strap_pkg::ADV_DEF_ALL;
		load_ctrl = 1'b1;
		load_adv = 1'b0;
		case (strap_mode)
			phy_strap_pkg::MODE_10_HALF: begin
				ctrl_def = phy_strap_pkg::CTRL_DEF_10_HALF;
			end
			phy_strap_pkg::MODE_10_FULL: begin
				ctrl_def = phy_strap_pkg::CTRL_DEF_10_FULL;
			end
			phy_strap_pkg::MODE_100_HALF: begin
				ctrl_def = phy_strap_pkg::CTRL_DEF_100_HALF;
			end
			phy_strap_pkg::MODE_100_FULL: begin
				ctrl_def = phy_strap_pkg::CTRL_DEF_100_FULL;
			end
			phy_strap_pkg::MODE_AN_100_HALF, phy_strap_pkg::MODE_REPEATER: begin
				// Repeater shares the defaults of negotiated 100 half.
				ctrl_def = phy_strap_pkg::CTRL_DEF_AN;
				adv_def = phy_strap_pkg::ADV_DEF_100_HALF;
				load_adv = 1'b1;
			end
			phy_strap_pkg::MODE_POWER_DOWN: begin
				// No control or ability defaults are loaded in this mode.
				load_ctrl = 1'b0;
			end
			default: begin
				// All capable; the free bits pick 100 full.
				ctrl_def = phy_strap_pkg::CTRL_DEF_ALL;
				adv_def = phy_strap_pkg::ADV_DEF_ALL;
				load_adv = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// Register port decode.
	// ==========================================================
	// All five address bits take part in the match.
	assign addr_match = (i_reg_phy_addr == phy_addr_reg);
	// Accesses are ignored until the straps are latched.
	assign wr_hit = i_reg_wr & addr_match & running;
	assign rd_hit = i_reg_rd & addr_match & running;

	// ==========================================================
	// Basic control register.
	// ==========================================================
	// Loads strap defaults once; software writes win later.
	always_ff @(posedge i_core_clk) begin
		if (reg_clear) begin
			ctrl_reg <= phy_strap_pkg::CTRL_RESET;
		end else if (capture && load_ctrl) begin
			ctrl_reg[phy_strap_pkg::CTRL_SPEED_100] <= ctrl_def[3];
			ctrl_reg[phy_strap_pkg::CTRL_AN_ENABLE] <= ctrl_def[2];
			ctrl_reg[phy_strap_pkg::CTRL_ISOLATE] <= ctrl_def[1];
			ctrl_reg[phy_strap_pkg::CTRL_FULL_DUPLEX] <= ctrl_def[0];
		end else if (wr_hit && i_reg_addr == phy_strap_pkg::REG_BASIC_CTRL) begin
			// A write setting soft reset wins over the self-clear.
			ctrl_reg <= i_reg_wdata;
		end else if (ctrl_reg[phy_strap_pkg::CTRL_SOFT_RESET]) begin
			// Soft reset lasts one cycle; other bits stay put.
			ctrl_reg[phy_strap_pkg::CTRL_SOFT_RESET] <= 1'b0;
		end
	end

	// ==========================================================
	// Advertisement register.
	// ==========================================================
	// Ability bits 8..5 take strap defaults in negotiating modes.
	always_ff @(posedge i_core_clk) begin
		if (reg_clear) begin
			adv_reg <= phy_strap_pkg::ADV_RESET;
		end else if (capture && load_adv) begin
			adv_reg[phy_strap_pkg::ADV_ABIL_LSB +: 4] <= adv_def;
		end else if (wr_hit && i_reg_addr == phy_strap_pkg::REG_ADVERT) begin
			adv_reg <= i_reg_wdata;
		end
	end

	// ==========================================================
	// Special modes register fields.
	// ==========================================================
	// Address comes from three straps; upper bits only by writes.
	always_ff @(posedge i_core_clk) begin
		if (reg_clear) begin
			phy_addr_reg <= phy_strap_pkg::ADDR_RESET;
		end else if (capture) begin
			phy_addr_reg <= {2'b00, pad_sync[phy_strap_pkg::PAD_ADDR_LSB +: 3]};
		end else if (wr_hit && i_reg_addr == phy_strap_pkg::REG_SPECIAL) begin
			// Takes effect from the next access on.
			phy_addr_reg <= i_reg_wdata[phy_strap_pkg::SPEC_ADDR_LSB +: 5];
		end
	end

	// Mode field mirrors the straps and may be rewritten.
	always_ff @(posedge i_core_clk) begin
		if (reg_clear) begin
			mode_field_reg <= phy_strap_pkg::MODE_RESET;
		end else if (capture) begin
			mode_field_reg <= strap_mode;
		end else if (wr_hit && i_reg_addr == phy_strap_pkg::REG_SPECIAL) begin
			mode_field_reg <= i_reg_wdata[phy_strap_pkg::SPEC_MODE_LSB +: 3];
		end
	end

	// Interface kind and regulator strap latch at release only.
	always_ff @(posedge i_core_clk) begin
		if (reg_clear) begin
			kind_reg <= 1'b0;
			regulator_disable_strap_reg <= 1'b0;
		end else if (capture) begin
			// Low selects MII; the kind bit reads back the choice.
			kind_reg <= pad_sync[phy_strap_pkg::PAD_MAC_IF];
			regulator_disable_strap_reg <= pad_sync[phy_strap_pkg::PAD_LED];
		end
	end

	// ==========================================================
	// Strap power-down.
	// ==========================================================
	// Only a soft reset with another mode written releases it.
	always_ff @(posedge i_core_clk) begin
		if (reg_clear) begin
			strap_pd_reg <= 1'b0;
		end else if (capture) begin
			strap_pd_reg <= (strap_mode == phy_strap_pkg::MODE_POWER_DOWN);
		end else if (ctrl_reg[phy_strap_pkg::CTRL_SOFT_RESET] &&
				mode_field_reg != phy_strap_pkg::MODE_POWER_DOWN) begin
			strap_pd_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Read port.
	// ==========================================================
	// Read view of the special modes register; other bits zero.
	always_comb begin
		special_view = 16'h0000;
		special_view[phy_strap_pkg::SPEC_ADDR_LSB +: 5] = phy_addr_reg;
		special_view[phy_strap_pkg::SPEC_MODE_LSB +: 3] = mode_field_reg;
		special_view[phy_strap_pkg::SPEC_KIND_BIT] = kind_reg;
	end

	// Data stand one cycle after the strobe; unmapped reads zero.
	always_ff @(posedge i_core_clk) begin
		if (reg_clear) begin
			o_reg_rdata <= 16'h0000;
			o_reg_rd_ack <= 1'b0;
		end else begin
			o_reg_rd_ack <= rd_hit;
			if (!rd_hit) begin
				o_reg_rdata <= 16'h0000;
			end else begin
				case (i_reg_addr)
					phy_strap_pkg::REG_BASIC_CTRL: begin
						o_reg_rdata <= ctrl_reg;
					end
					phy_strap_pkg::REG_ADVERT: begin
						o_reg_rdata <= adv_reg;
					end
					phy_strap_pkg::REG_SPECIAL: begin
						o_reg_rdata <= special_view;
					end
					default: begin
						o_reg_rdata <= 16'h0000;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Shared pads.
	// ==========================================================
	// Pads float while straps are sampled, then drive normal duties.
	always_ff @(posedge i_core_clk) begin
		if (reg_clear || !running) begin
			o_pad_oe <= 8'h00;
			o_pad_out <= 8'h00;
		end else begin
			o_pad_oe <= phy_strap_pkg::PAD_OE_RUN;
			o_pad_out[6:0] <= i_pad_func[6:0];
			// Indicator is active low when the strap was high.
			o_pad_out[phy_strap_pkg::PAD_LED] <= i_pad_func[phy_strap_pkg::PAD_LED] ^ regulator_disable_strap_reg;
		end
	end

	// ==========================================================
	// Configuration outputs.
	// ==========================================================
	// Registered copies of the register state for the 10/100 logic.
	always_ff @(posedge i_core_clk) begin
		if (reg_clear) begin
			o_speed_100 <= 1'b0;
			o_full_duplex <= 1'b0;
			o_autoneg_en <= 1'b0;
			o_adv_abilities <= 4'h0;
			o_crs_on_tx <= 1'b0;
			o_repeater_mode <= 1'b0;
			o_power_down <= 1'b0;
			o_soft_reset <= 1'b0;
			o_rmii_mode <= 1'b0;
			o_phy_address <= 5'h00;
			o_scrambler_seed <= 5'h00;
			o_regulator_off <= 1'b0;
			o_config_ready <= 1'b0;
		end else begin
			// Speed, duplex, negotiation and abilities follow register bits, not straps.
			o_speed_100 <= ctrl_reg[phy_strap_pkg::CTRL_SPEED_100];
			o_full_duplex <= ctrl_reg[phy_strap_pkg::CTRL_FULL_DUPLEX];
			o_autoneg_en <= ctrl_reg[phy_strap_pkg::CTRL_AN_ENABLE];
			o_adv_abilities <= adv_reg[phy_strap_pkg::ADV_ABIL_LSB +: 4];
			// Carrier sense on transmit only in modes 100 half and negotiated 100 half, not in repeater mode.
			o_crs_on_tx <= (mode_field_reg == phy_strap_pkg::MODE_100_HALF) ||
				(mode_field_reg == phy_strap_pkg::MODE_AN_100_HALF);
			o_repeater_mode <= (mode_field_reg == phy_strap_pkg::MODE_REPEATER);
			o_power_down <= ctrl_reg[phy_strap_pkg::CTRL_POWER_DOWN] | strap_pd_reg;
			o_soft_reset <= ctrl_reg[phy_strap_pkg::CTRL_SOFT_RESET];
			o_rmii_mode <= kind_reg;
			o_phy_address <= phy_addr_reg;
			o_scrambler_seed <= phy_addr_reg;
			o_regulator_off <= regulator_disable_strap_reg;
			o_config_ready <= running;
		end
	end

endmodule
`default_nettype wire

// file: phy_strap_pkg.sv
// Constants shared by the strap configuration loader and its helpers.
`default_nettype none
package phy_strap_pkg;

	// ==========================================================
	// Register indices on the management register port.
	// ==========================================================
	localparam logic [4:0] REG_BASIC_CTRL = 5'h00; // Basic control register.
	localparam logic [4:0] REG_ADVERT = 5'h04; // Advertisement register.
	localparam logic [4:0] REG_SPECIAL = 5'h12; // Special modes register (index 18).

	// ==========================================================
	// Field positions.
	// ==========================================================
	localparam int CTRL_SOFT_RESET = 15; // Self-clearing soft reset.
	localparam int CTRL_SPEED_100 = 13; // Speed select.
	localparam int CTRL_AN_ENABLE = 12; // Auto-negotiation enable.
	localparam int CTRL_POWER_DOWN = 11; // General power-down.
	localparam int CTRL_ISOLATE = 10; // Isolate.
	localparam int CTRL_FULL_DUPLEX = 8; // Duplex mode.
	localparam int ADV_ABIL_LSB = 5; // Lowest of the four ability bits 8..5.
	localparam int SPEC_ADDR_LSB = 0; // Address field 4:0.
	localparam int SPEC_MODE_LSB = 5; // Mode field 7:5.
	localparam int SPEC_KIND_BIT = 14; // MAC interface kind bit.

	// ==========================================================
	// Values after reset.
	// ==========================================================
	localparam logic [15:0] CTRL_RESET = 16'h0000; // Control before straps load.
	localparam logic [15:0] ADV_RESET = 16'h01E1; // Advertisement before straps load.
	localparam logic [4:0] ADDR_RESET = 5'h00; // Address with all straps low.
	localparam logic [2:0] MODE_RESET = 3'h0; // Mode field before straps load.

	// ==========================================================
	// Operating mode strap codes.
	// ==========================================================
	localparam logic [2:0] MODE_10_HALF = 3'h0; // 10 Mb/s half duplex.
	localparam logic [2:0] MODE_10_FULL = 3'h1; // 10 Mb/s full duplex.
	localparam logic [2:0] MODE_100_HALF = 3'h2; // 100 Mb/s half duplex.
	localparam logic [2:0] MODE_100_FULL = 3'h3; // 100 Mb/s full duplex.
	localparam logic [2:0] MODE_AN_100_HALF = 3'h4; // Negotiate 100 half only.
	localparam logic [2:0] MODE_REPEATER = 3'h5; // Repeater, negotiate 100 half.
	localparam logic [2:0] MODE_POWER_DOWN = 3'h6; // Wake up powered down.
	localparam logic [2:0] MODE_ALL_CAPABLE = 3'h7; // Negotiate everything.

	// ==========================================================
	// Defaults for control bits {13,12,10,8} and ability bits 8..5.
	// ==========================================================
	localparam logic [3:0] CTRL_DEF_10_HALF = 4'h0; // Pattern 0000.
	localparam logic [3:0] CTRL_DEF_10_FULL = 4'h1; // Pattern 0001.
	localparam logic [3:0] CTRL_DEF_100_HALF = 4'h8; // Pattern 1000.
	localparam logic [3:0] CTRL_DEF_100_FULL = 4'h9; // Pattern 1001.
	localparam logic [3:0] CTRL_DEF_AN = 4'hC; // Pattern 1100.
	localparam logic [3:0] CTRL_DEF_ALL = 4'hD; // Pattern X10X, free bits set.
	localparam logic [3:0] ADV_DEF_100_HALF = 4'h4; // Pattern 0100.
	localparam logic [3:0] ADV_DEF_ALL = 4'hF; // Pattern 1111.

	// ==========================================================
	// Shared pads and timing.
	// ==========================================================
	localparam int PAD_COUNT = 8; // Strap pads handled here.
	localparam int PAD_ADDR_LSB = 0; // Address straps on pads 2:0.
	localparam int PAD_MODE_LSB = 3; // Mode straps on pads 5:3.
	localparam int PAD_MAC_IF = 6; // MAC interface select pad.
	localparam int PAD_LED = 7; // Regulator strap and indicator pad.
	localparam logic [7:0] PAD_OE_RUN = 8'hFF; // All pads driven in normal use.
	localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2; // Synchroniser fill time.

	// Loader sequence states, one-hot.
	typedef enum logic [2:0] {
		ST_RESET = 3'b001,
		ST_SETTLE = 3'b010,
		ST_RUN = 3'b100
	} load_state_e;

endpackage
`default_nettype wire

// file: strap_sync.sv
// Two-stage synchroniser for pad levels entering the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module strap_sync #(
	parameter int WIDTH = 9
) (
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// Asynchronous levels in, synchronised levels out.
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	// First stage; only the second stage reads it.
	logic [WIDTH-1:0] meta_reg;

	// ==========================================================
	// One synchroniser per bit.
	// ==========================================================
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			// Both stages clear to zero under reset.
			always_ff @(posedge i_core_clk) begin
				if (i_sys_rst) begin
					meta_reg[g] <= 1'b0;
					o_sync[g] <= 1'b0;
				end else begin
					meta_reg[g] <= i_async[g];
					o_sync[g] <= meta_reg[g];
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

// file: phy_strap_config_loader_checker.sv
// Port assertions for the strap configuration loader.
`timescale 1ns/1ps
`default_nettype none
module phy_strap_checker (
	// Clock and reset.
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// Register port.
	input wire logic [4:0] i_reg_phy_addr,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [15:0] o_reg_rdata,
	input wire logic o_reg_rd_ack,
	// Pads and configuration.
	input wire logic [7:0] i_pad_func,
	input wire logic [7:0] o_pad_out,
	input wire logic [7:0] o_pad_oe,
	input wire logic o_soft_reset,
	input wire logic o_rmii_mode,
	input wire logic [4:0] o_phy_address,
	input wire logic [4:0] o_scrambler_seed,
	input wire logic o_regulator_off,
	input wire logic o_config_ready
);
	// All checks share the core clock and the power-on reset.
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	AST_SEED: assert property (o_config_ready |-> o_scrambler_seed == o_phy_address)
		else $error("seed differs from address");
	AST_ACK: assert property (i_reg_rd && o_config_ready && !$past(i_reg_wr) && i_reg_phy_addr == o_phy_address |=> o_reg_rd_ack)
		else $error("matching read not answered");
	AST_NOACK: assert property (i_reg_rd && !$past(i_reg_wr) && i_reg_phy_addr != o_phy_address |=> !o_reg_rd_ack)
		else $error("foreign read answered");
	AST_RDATA: assert property (!o_reg_rd_ack |-> o_reg_rdata == 16'h0000)
		else $error("read data without answer");
	AST_SRST: assert property (o_soft_reset |=> !o_soft_reset)
		else $error("soft reset pulse too long");
	AST_LED: assert property (o_config_ready && $past(o_config_ready) |-> o_pad_out[7] == ($past(i_pad_func[7]) ^ o_regulator_off))
		else $error("indicator polarity wrong");
	AST_PADF: assert property (o_config_ready && $past(o_config_ready) |-> o_pad_out[6:0] == $past(i_pad_func[6:0]))
		else $error("pad function not passed");
	AST_OE: assert property (o_pad_oe == (o_config_ready ? 8'hFF : 8'h00))
		else $error("pad enable wrong");
	AST_HOLD: assert property (o_config_ready && $past(o_config_ready) |-> $stable(o_rmii_mode) && $stable(o_regulator_off))
		else $error("latched strap changed");
endmodule
bind phy_strap_config_loader phy_strap_checker i_chk (.*);
`default_nettype wire

// file: strap_board.sv
// Board model: strap resistors on pads that the device shares.
`timescale 1ns/1ps
`default_nettype none
module strap_board (
	input wire logic [7:0] i_strap, // Resistor levels.
	input wire logic [7:0] i_pad_out, // Device drive.
	input wire logic [7:0] i_pad_oe, // Device enable.
	output logic [7:0] o_pad // Pad level seen.
);
	// A released pad settles to its resistor, a driven one shows the device.
	assign o_pad = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_strap);
endmodule
`default_nettype wire

// file: test_phy_strap_config_loader.sv
// Self-checking bench for the strap configuration loader.
`timescale 1ns/1ps
`default_nettype none
module test_phy_strap_config_loader;
	logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_hw_reset_n = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
	logic [7:0] strap = 8'h07, i_pad_func = 8'h00, i_pad_in, o_pad_out, o_pad_oe;
	logic [4:0] i_reg_phy_addr = 5'h00, i_reg_addr = 5'h00, o_phy_address, o_scrambler_seed, a;
	logic [15:0] i_reg_wdata = 16'h0000, o_reg_rdata;
	logic o_reg_rd_ack, o_speed_100, o_full_duplex, o_autoneg_en, o_crs_on_tx, o_repeater_mode;
	logic o_power_down, o_soft_reset, o_rmii_mode, o_regulator_off, o_config_ready;
	logic [3:0] o_adv_abilities;
	logic [16:0] got;
	// Rows: control {13,12,10,8}, ability bits, then crs, repeater, power-down.
	logic [11:0] tbl [8] = '{12'h0F0, 12'h1F0, 12'h8F4, 12'h9F0, 12'hC44, 12'hC42, 12'h0F1, 12'hDF0};
	int errors = 0, total_checks = 0;
	always #50 i_core_clk = ~i_core_clk;
	// A moving pattern on the normal pad functions.
	always @(posedge i_core_clk) i_pad_func <= i_pad_func + 8'h01;
	strap_board i_brd (.i_strap(strap), .i_pad_out(o_pad_out), .i_pad_oe(o_pad_oe), .o_pad(i_pad_in));
	phy_strap_config_loader i_dut (.*);
	task check(input logic [16:0] g, input logic [16:0] e);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task report_and_stop();
		$display("checks %0d, mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// One register access; answer and data are sampled in the cycle after.
	task acc(input logic w, input logic [4:0] p, input logic [4:0] r, input logic [15:0] d);
		@(posedge i_core_clk);
		i_reg_phy_addr <= p;
		i_reg_addr <= r;
		i_reg_wdata <= d;
		i_reg_wr <= w;
		i_reg_rd <= !w;
		@(posedge i_core_clk);
		i_reg_wr <= 1'b0;
		i_reg_rd <= 1'b0;
		@(negedge i_core_clk);
		got = {o_reg_rd_ack, o_reg_rdata};
	endtask
	// Optionally pulse the pin reset with new straps, then wait for the loader.
	task load(input logic [7:0] s, input logic pulse);
		if (pulse) begin
			@(posedge i_core_clk);
			strap <= s;
			i_hw_reset_n <= 1'b0;
			repeat (6) @(posedge i_core_clk);
			i_hw_reset_n <= 1'b1;
			@(negedge i_core_clk);
			check({9'h000, o_pad_oe}, 17'h00000);
		end
		for (int n = 0; n < 30 && o_config_ready !== 1'b1; n++) @(posedge i_core_clk);
		@(negedge i_core_clk);
		check({16'h0000, o_config_ready}, 17'h00001);
	endtask
	initial begin
		repeat (16) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			load({i[1], i[0], i[2:0], ~i[2:0]}, i != 0);
			a = {2'b00, ~i[2:0]};
			acc(1'b0, a, 5'h00, 16'h0000);
			check(got, {3'b100, tbl[i][11:10], 1'b0, tbl[i][9], 1'b0, tbl[i][8], 8'h00});
			acc(1'b0, a, 5'h04, 16'h0000);
			check(got, {8'h80, tbl[i][7:4], 5'h01});
			acc(1'b0, a, 5'h12, 16'h0000);
			check(got, {2'b10, i[0], 6'h00, i[2:0], a});
			check({11'h000, o_speed_100, o_autoneg_en, o_full_duplex, o_crs_on_tx, o_repeater_mode, o_power_down},
				{11'h000, tbl[i][11:10], tbl[i][8], tbl[i][2:0]});
			check({6'h00, o_adv_abilities, o_rmii_mode, o_regulator_off, o_phy_address},
				{6'h00, tbl[i][7:4], i[0], i[1], a});
			check({12'h000, o_scrambler_seed}, {12'h000, a});
			$display("strap row %0d done", i);
		end
		acc(1'b0, 5'h08, 5'h00, 16'h0000);
		check(got, 17'h00000);
		acc(1'b1, 5'h00, 5'h12, 16'h00F5);
		acc(1'b0, 5'h15, 5'h12, 16'h0000);
		check(got, 17'h140F5);
		acc(1'b0, 5'h00, 5'h00, 16'h0000);
		check(got, 17'h00000);
		check({12'h000, o_phy_address}, 17'h00015);
		$display("address rewrite done");
		load(8'h30, 1'b1);
		acc(1'b1, 5'h00, 5'h12, 16'h0060);
		check({16'h0000, o_power_down}, 17'h00001);
		acc(1'b1, 5'h00, 5'h00, 16'h8000);
		@(posedge i_core_clk);
		@(negedge i_core_clk);
		check({16'h0000, o_soft_reset}, 17'h00001);
		repeat (2) @(posedge i_core_clk);
		@(negedge i_core_clk);
		check({16'h0000, o_power_down}, 17'h00000);
		acc(1'b0, 5'h00, 5'h00, 16'h0000);
		check(got, 17'h10000);
		$display("power-down exit done");
		report_and_stop();
	end
	// Watchdog against a hang.
	initial begin
		repeat (3000) @(posedge i_core_clk);
		errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire
